/* shared/mode_map_pkg.sv */
// constants for the mode control and resource map block
package mode_map_pkg;
    // register offsets inside the register block
    localparam logic [8:0] RAM_POS_OFS = 9'h010;
    localparam logic [8:0] REG_POS_OFS = 9'h011;
    localparam logic [8:0] EE_POS_OFS = 9'h012;
    localparam logic [8:0] MODE_OFS = 9'h01F;
    localparam logic [8:0] PORT_E_DATA_OFS = 9'h008;
    localparam logic [8:0] PORT_E_DIR_OFS = 9'h009;
    // mode register fields
    localparam int SPECIAL_MODE_FLAG_N_BIT = 7;
    localparam int MODE_SELECT_B_BIT = 6;
    localparam int MODE_SELECT_A_BIT = 5;
    localparam int E_STRETCH_ENABLE_BIT = 4;
    localparam int INTERNAL_VISIBILITY_BIT = 3;
    localparam int EXT_BUS_WAIT_STOP_BIT = 2;
    localparam int EME_BIT = 0;
    // position register fields
    localparam int POS_LSB = 3;
    localparam int MAP_IF_WAIT_STOP_BIT = 0;
    localparam int EE_POS_LSB = 4;
    localparam int EEON_BIT = 0;
    localparam logic [4:0] RAM_POS_RESET = 5'h01;
    localparam logic [4:0] REG_POS_RESET = 5'h00;
    localparam logic [3:0] EE_POS_RESET = 4'h0;
    localparam logic [3:0] EE_FIRST_PAGE = 4'hD;
    // modes as {special_mode_flag_n, mode_select_b, mode_select_a}
    localparam logic [2:0] MODE_SPECIAL_SINGLE = 3'h0;
    localparam logic [2:0] MODE_SPECIAL_NARROW = 3'h1;
    localparam logic [2:0] MODE_PERIPHERAL = 3'h2;
    localparam logic [2:0] MODE_SPECIAL_WIDE = 3'h3;
    localparam logic [2:0] MODE_NORMAL_NARROW = 3'h5;
    localparam logic [2:0] MODE_RESERVED = 3'h6;
    // time the external bus gets to finish before it stops in wait
    localparam int CLK_PERIOD_NS = 10;
    localparam int EXT_STOP_DELAY_NS = 80;
    localparam int EXT_STOP_CYCLES = (EXT_STOP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* logic/resource_decoder.sv */
// fixed-precedence decoder of the internal resources
`timescale 1ns/1ps
`default_nettype none
module resource_decoder
    import mode_map_pkg::*;
(
    input wire logic [15:0] addr_in,
    input wire logic debug_active_in,
    input wire logic serial_access_in,
    input wire logic [4:0] reg_pos_in,
    input wire logic [4:0] ram_pos_in,
    input wire logic [3:0] ee_pos_in,
    input wire logic ee_on_in,
    input wire logic flash_on_in,
    input wire logic flash_upper_in,
    input wire logic port_e_removed_in,
    output logic sel_debug_rom_out,
    output logic sel_debug_regs_out,
    output logic sel_regs_out,
    output logic sel_ram_out,
    output logic sel_eeprom_out,
    output logic sel_flash_out,
    output logic sel_external_out
);
    logic rom_hit;
    logic reg_hit;
    logic ram_hit;
    logic ee_hit;
    logic flash_hit;
    logic port_e_hit;

    // serial debug accesses still reach user memory under the debug rom
    assign rom_hit = debug_active_in && !serial_access_in && addr_in[15:8] == 8'hFF;
    assign port_e_hit = addr_in[8:0] == PORT_E_DATA_OFS || addr_in[8:0] == PORT_E_DIR_OFS;
    assign reg_hit = addr_in[15:11] == reg_pos_in && addr_in[10:9] == 2'h0
        && !(port_e_removed_in && port_e_hit);
    assign ram_hit = addr_in[15:11] == ram_pos_in && !addr_in[10];
    assign ee_hit = ee_on_in && addr_in[15:12] == ee_pos_in && addr_in[11:8] >= EE_FIRST_PAGE;
    assign flash_hit = flash_on_in && addr_in[15] == flash_upper_in;

    always_comb begin
        sel_debug_rom_out = rom_hit;
        sel_debug_regs_out = rom_hit && addr_in[7:0] <= 8'h06;
        sel_regs_out = !rom_hit && reg_hit;
        sel_ram_out = !rom_hit && !reg_hit && ram_hit;
        sel_eeprom_out = !rom_hit && !reg_hit && !ram_hit && ee_hit;
        sel_flash_out = !rom_hit && !reg_hit && !ram_hit && !ee_hit && flash_hit;
        sel_external_out = !(rom_hit || reg_hit || ram_hit || ee_hit || flash_hit);
    end
endmodule
`default_nettype wire

/* logic/mode_map_control.sv */
// operating mode control, position registers and resource selection
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module mode_map_control
    import mode_map_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic background_pin_in,
    input wire logic mode_select_b_in,
    input wire logic mode_select_a_in,
    input wire logic [8:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    input wire logic wait_mode_in,
    input wire logic [15:0] cpu_addr_in,
    input wire logic cpu_idle_in,
    input wire logic ext_access_in,
    input wire logic int_access_in,
    input wire logic flash_on_in,
    input wire logic flash_upper_in,
    input wire logic debug_enable_cmd_in,
    input wire logic debug_activate_cmd_in,
    input wire logic enter_background_instruction_in,
    input wire logic debug_exit_in,
    input wire logic [15:0] dbg_addr_in,
    input wire logic dbg_req_in,
    input wire logic dbg_write_in,
    output logic dbg_grant_out,
    output logic dbg_write_ok_out,
    output logic debug_mode_out,
    output logic vectors_from_debug_out,
    output logic [2:0] mode_out,
    output logic e_clock_out,
    output logic e_stretch_out,
    output logic visibility_out,
    output logic wide_visible_format_out,
    output logic narrow_bus_out,
    output logic port_e_removed_out,
    output logic ext_bus_shutdown_out,
    output logic sel_debug_rom_out,
    output logic sel_debug_regs_out,
    output logic sel_regs_out,
    output logic sel_ram_out,
    output logic sel_eeprom_out,
    output logic sel_flash_out,
    output logic sel_external_out
);
    logic special_mode_flag_n_reg;
    logic mode_select_b_reg;
    logic mode_select_a_reg;
    logic e_stretch_enable_reg;
    logic internal_visibility_reg;
    logic ext_bus_wait_stop_reg;
    logic eme_reg;
    logic mode_written_reg;
    logic first_done_reg;
    logic [4:0] ram_pos_reg;
    logic [4:0] reg_pos_reg;
    logic map_if_wait_stop_reg;
    logic [3:0] ee_pos_reg;
    logic eeon_reg;
    logic ram_written_reg;
    logic reg_written_reg;
    logic ee_written_reg;
    logic debug_enable_reg;
    logic debug_active_reg;
    logic e_clock_reg;
    logic [7:0] stop_cnt_reg;
    logic ext_stop_reg;
    logic [7:0] rdata_reg;
    logic [2:0] pin_mode;
    logic [2:0] pin_mode_next;
    logic [2:0] mode;
    logic [2:0] mode_next;
    logic special;
    logic expanded;
    logic single_chip;
    logic peripheral;
    logic first_wr;
    logic bus_ok;
    logic wr;
    logic rd;
    logic mode_hit;
    logic ee_on;
    logic [15:0] dec_addr;

    assign pin_mode = {background_pin_in, mode_select_b_in, mode_select_a_in};
    // the reserved pin code comes up as peripheral mode
    assign pin_mode_next = pin_mode == MODE_RESERVED ? MODE_PERIPHERAL : pin_mode;
    assign mode = {special_mode_flag_n_reg, mode_select_b_reg, mode_select_a_reg};
    assign special = !special_mode_flag_n_reg;
    assign expanded = mode_select_a_reg;
    assign single_chip = !mode_select_b_reg && !mode_select_a_reg;
    assign peripheral = mode == MODE_PERIPHERAL;
    assign first_wr = special && !first_done_reg;
    // wait with the stop bit set freezes the whole register interface
    assign bus_ok = !(map_if_wait_stop_reg && wait_mode_in);
    assign wr = reg_write_in && bus_ok;
    assign rd = reg_read_in && bus_ok;
    assign mode_hit = reg_addr_in == MODE_OFS && !peripheral;
    assign mode_next = {first_wr || !special ? special_mode_flag_n_reg : reg_wdata_in[SPECIAL_MODE_FLAG_N_BIT],
        reg_wdata_in[MODE_SELECT_B_BIT], reg_wdata_in[MODE_SELECT_A_BIT]};

    // mode register; reset is synchronous so the pins load while it is held
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            {special_mode_flag_n_reg, mode_select_b_reg, mode_select_a_reg} <= pin_mode_next;
            e_stretch_enable_reg <= 1'b1;
            internal_visibility_reg <= !pin_mode_next[2];
            eme_reg <= !pin_mode_next[2];
            ext_bus_wait_stop_reg <= 1'b0;
            mode_written_reg <= 1'b0;
            first_done_reg <= 1'b0;
        end else if (wr && mode_hit) begin
            mode_written_reg <= 1'b1;
            first_done_reg <= 1'b1;
            ext_bus_wait_stop_reg <= reg_wdata_in[EXT_BUS_WAIT_STOP_BIT];
            if (special && !first_wr) begin
                special_mode_flag_n_reg <= reg_wdata_in[SPECIAL_MODE_FLAG_N_BIT];
            end
            if ((special || !mode_written_reg) && mode_next != MODE_PERIPHERAL
                && mode_next != MODE_RESERVED) begin
                mode_select_b_reg <= mode_next[1];
                mode_select_a_reg <= mode_next[0];
            end
            if (special || !mode_written_reg) begin
                e_stretch_enable_reg <= reg_wdata_in[E_STRETCH_ENABLE_BIT];
            end
            if (special ? !first_wr : !mode_written_reg) begin
                internal_visibility_reg <= reg_wdata_in[INTERNAL_VISIBILITY_BIT];
                eme_reg <= reg_wdata_in[EME_BIT];
            end
        end
    end

    // position registers; a write shows in the decode from the next cycle
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            ram_pos_reg <= RAM_POS_RESET;
            reg_pos_reg <= REG_POS_RESET;
            map_if_wait_stop_reg <= 1'b0;
            ee_pos_reg <= EE_POS_RESET;
            eeon_reg <= 1'b1;
            ram_written_reg <= 1'b0;
            reg_written_reg <= 1'b0;
            ee_written_reg <= 1'b0;
        end else if (wr) begin
            if (reg_addr_in == RAM_POS_OFS && (special || !ram_written_reg)) begin
                ram_pos_reg <= reg_wdata_in[POS_LSB +: 5];
                ram_written_reg <= 1'b1;
            end
            if (reg_addr_in == REG_POS_OFS && (special || !reg_written_reg)) begin
                reg_pos_reg <= reg_wdata_in[POS_LSB +: 5];
                map_if_wait_stop_reg <= reg_wdata_in[MAP_IF_WAIT_STOP_BIT];
                reg_written_reg <= 1'b1;
            end
            if (reg_addr_in == EE_POS_OFS && (special || !ee_written_reg)) begin
                ee_pos_reg <= reg_wdata_in[EE_POS_LSB +: 4];
                ee_written_reg <= 1'b1;
            end
            if (reg_addr_in == EE_POS_OFS) begin
                eeon_reg <= reg_wdata_in[EEON_BIT];
            end
        end
    end

    // debug enable and activation; special single-chip comes up active
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            debug_enable_reg <= pin_mode_next == MODE_SPECIAL_SINGLE;
            debug_active_reg <= pin_mode_next == MODE_SPECIAL_SINGLE;
        end else begin
            if (debug_enable_cmd_in) begin
                debug_enable_reg <= 1'b1;
            end
            // activation wins over an exit in the same cycle
            if ((debug_activate_cmd_in || enter_background_instruction_in)
                && debug_enable_reg) begin
                debug_active_reg <= 1'b1;
            end else if (debug_exit_in) begin
                debug_active_reg <= 1'b0;
            end
        end
    end

    // E clock: free toggle, or held during stretched accesses
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            e_clock_reg <= 1'b0;
        end else if (e_stretch_out && ext_access_in) begin
            e_clock_reg <= 1'b1;
        end else if (e_stretch_out && int_access_in && !visibility_out) begin
            e_clock_reg <= 1'b0;
        end else begin
            e_clock_reg <= !e_clock_reg;
        end
    end

    // external bus stop in wait, delayed so the last cycle can finish
    always_ff @(posedge clk_in) begin
        if (!reset_n_in || !(ext_bus_wait_stop_reg && wait_mode_in)) begin
            stop_cnt_reg <= 8'h00;
            ext_stop_reg <= 1'b0;
        end else if (stop_cnt_reg == 8'(EXT_STOP_CYCLES - 1)) begin
            ext_stop_reg <= 1'b1;
        end else begin
            stop_cnt_reg <= stop_cnt_reg + 8'h01;
        end
    end

    // read data stand in the cycle after the read strobe only
    always_ff @(posedge clk_in) begin
        if (!reset_n_in || !rd) begin
            rdata_reg <= 8'h00;
        end else if (mode_hit) begin
            rdata_reg <= {special_mode_flag_n_reg, mode_select_b_reg, mode_select_a_reg, e_stretch_out, internal_visibility_reg,
                ext_bus_wait_stop_reg, 1'b0, eme_reg};
        end else if (reg_addr_in == RAM_POS_OFS) begin
            rdata_reg <= {ram_pos_reg, 3'h0};
        end else if (reg_addr_in == REG_POS_OFS) begin
            rdata_reg <= {reg_pos_reg, 2'h0, map_if_wait_stop_reg};
        end else if (reg_addr_in == EE_POS_OFS) begin
            rdata_reg <= {ee_pos_reg, 3'h0, ee_on};
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign reg_rdata_out = rdata_reg;
    assign ee_on = eeon_reg || single_chip;
    assign mode_out = mode;
    assign e_stretch_out = e_stretch_enable_reg || expanded;
    assign e_clock_out = e_clock_reg;
    // normal narrow mode ignores the visibility bit
    assign visibility_out = internal_visibility_reg && expanded && mode != MODE_NORMAL_NARROW;
    assign wide_visible_format_out = visibility_out && mode == MODE_SPECIAL_NARROW;
    assign narrow_bus_out = expanded && !mode_select_b_reg;
    assign port_e_removed_out = eme_reg && expanded;
    assign ext_bus_shutdown_out = ext_stop_reg;
    assign debug_mode_out = debug_active_reg;
    assign vectors_from_debug_out = debug_active_reg;
    // debug accesses only take cycles the cpu leaves idle
    assign dbg_grant_out = dbg_req_in && cpu_idle_in;
    assign dec_addr = dbg_grant_out ? dbg_addr_in : cpu_addr_in;
    assign dbg_write_ok_out = dbg_grant_out && dbg_write_in && (sel_regs_out || sel_ram_out);

    resource_decoder u_decoder (
        .addr_in(dec_addr),
        .debug_active_in(debug_active_reg),
        .serial_access_in(dbg_grant_out),
        .reg_pos_in(reg_pos_reg),
        .ram_pos_in(ram_pos_reg),
        .ee_pos_in(ee_pos_reg),
        .ee_on_in(ee_on),
        .flash_on_in(flash_on_in),
        .flash_upper_in(flash_upper_in),
        .port_e_removed_in(port_e_removed_out),
        .sel_debug_rom_out(sel_debug_rom_out),
        .sel_debug_regs_out(sel_debug_regs_out),
        .sel_regs_out(sel_regs_out),
        .sel_ram_out(sel_ram_out),
        .sel_eeprom_out(sel_eeprom_out),
        .sel_flash_out(sel_flash_out),
        .sel_external_out(sel_external_out)
    );

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_mode_capture;
        $rose(reset_n_in) |-> mode == $past(pin_mode_next);
    endproperty
    a_mode_capture: assert property (p_mode_capture) else $error("mode not captured");

    property p_debug_boot;
        $rose(reset_n_in) && mode == MODE_SPECIAL_SINGLE |-> debug_active_reg && debug_enable_reg;
    endproperty
    a_debug_boot: assert property (p_debug_boot) else $error("debug not active");

    property p_no_periph;
        mode != MODE_PERIPHERAL |=> mode != MODE_PERIPHERAL && mode != MODE_RESERVED;
    endproperty
    a_no_periph: assert property (p_no_periph) else $error("illegal mode selected");

    property p_e_stretch_enable_exp;
        expanded |-> e_stretch_out;
    endproperty
    a_e_stretch_enable_exp: assert property (p_e_stretch_enable_exp) else $error("stretch not forced");

    property p_nn_vis;
        mode == MODE_NORMAL_NARROW |-> !visibility_out && !wide_visible_format_out;
    endproperty
    a_nn_vis: assert property (p_nn_vis) else $error("visibility in normal narrow");

    property p_ram_pos;
        wr && special && reg_addr_in == RAM_POS_OFS
            |=> ram_pos_reg == $past(reg_wdata_in[7:3]);
    endproperty
    a_ram_pos: assert property (p_ram_pos) else $error("ram position not updated");

    property p_wait_freeze;
        map_if_wait_stop_reg && wait_mode_in |=> $stable(ram_pos_reg) && $stable(reg_pos_reg);
    endproperty
    a_wait_freeze: assert property (p_wait_freeze) else $error("map written in wait");

    property p_onehot;
        $onehot({sel_debug_rom_out, sel_regs_out, sel_ram_out, sel_eeprom_out,
            sel_flash_out, sel_external_out});
    endproperty
    a_onehot: assert property (p_onehot) else $error("select not one-hot");

    property p_rom_top;
        debug_active_reg && !dbg_grant_out && cpu_addr_in[15:8] == 8'hFF |-> sel_debug_rom_out;
    endproperty
    a_rom_top: assert property (p_rom_top) else $error("debug rom not selected");

    property p_ext_stop;
        ext_bus_wait_stop_reg && wait_mode_in [*3] ##1 !ext_bus_shutdown_out
            |-> !$past(ext_bus_shutdown_out) || !$past(wait_mode_in);
    endproperty
    a_ext_stop: assert property (p_ext_stop) else $error("bus stop dropped");

    property p_dbg_wr;
        dbg_write_ok_out |-> dbg_grant_out && !sel_eeprom_out && !sel_flash_out;
    endproperty
    a_dbg_wr: assert property (p_dbg_wr) else $error("debug wrote read-only memory");

    property p_periph_hidden;
        peripheral && rd && reg_addr_in == MODE_OFS |=> reg_rdata_out == 8'h00;
    endproperty
    a_periph_hidden: assert property (p_periph_hidden) else $error("mode seen in peripheral");

    c_debug_entry: cover property (debug_enable_reg ##1 enter_background_instruction_in
        ##1 debug_active_reg);
    c_bus_stop: cover property ($rose(ext_bus_shutdown_out));
    c_relocate: cover property (wr && reg_addr_in == REG_POS_OFS ##1 sel_regs_out);
endmodule
`default_nettype wire

/* sim/debug_host_model.sv */
// debug host model that holds each request until the block grants it
`timescale 1ns/1ps
`default_nettype none
module debug_host_model (
    input wire logic clk_in,
    input wire logic start_in,
    input wire logic [15:0] addr_in,
    input wire logic write_in,
    input wire logic grant_in,
    output logic req_out,
    output logic [15:0] addr_out,
    output logic write_out
);
    initial begin
        req_out = 1'b0;
        addr_out = 16'h0000;
        write_out = 1'b0;
    end
    // request and qualifiers stay put until the edge that sees the grant
    always @(posedge clk_in) begin
        if (req_out && grant_in) begin
            req_out <= 1'b0;
            // released lines show junk so a stale address cannot pass
            addr_out <= ~addr_out;
            write_out <= ~write_out;
        end else if (!req_out && start_in) begin
            req_out <= 1'b1;
            addr_out <= addr_in;
            write_out <= write_in;
        end
    end
endmodule
`default_nettype wire

/* sim/mode_map_control_tb.sv */
// self-checking bench for the mode control and resource map block
`timescale 1ns/1ps
`default_nettype none
module mode_map_control_tb;
    import mode_map_pkg::*;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [2:0] pins = 3'h4;
    logic [8:0] ra = 9'h000;
    logic [7:0] wd = 8'h00;
    logic [15:0] ca = 16'h0000;
    logic [15:0] da = 16'h0000;
    logic wr = 1'b0, rd = 1'b0, wt = 1'b0, idle = 1'b0, go = 1'b0, dw = 1'b0;
    logic en = 1'b0, act = 1'b0, ex = 1'b0, xa = 1'b0, ia = 1'b0, bg = 1'b0, one = 1'b1;
    logic req, grant, hw, wok, dbm, vec, e_stretch_enable, vis, wide, pe, shut, ec, nb;
    logic [15:0] haddr;
    logic [7:0] rdata;
    logic [7:0] v;
    logic [2:0] mode;
    logic [6:0] sv;
    int num_errors = 0;
    int num_checks = 0;
    always #5 clk_in = ~clk_in;
    debug_host_model host (.clk_in(clk_in), .start_in(go), .addr_in(da), .write_in(dw),
        .grant_in(grant), .req_out(req), .addr_out(haddr), .write_out(hw));
    mode_map_control dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .background_pin_in(pins[2]), .mode_select_b_in(pins[1]), .mode_select_a_in(pins[0]),
        .reg_addr_in(ra), .reg_wdata_in(wd), .reg_write_in(wr), .reg_read_in(rd),
        .reg_rdata_out(rdata), .wait_mode_in(wt), .cpu_addr_in(ca), .cpu_idle_in(idle),
        .ext_access_in(xa), .int_access_in(ia), .flash_on_in(one), .flash_upper_in(one),
        .debug_enable_cmd_in(en), .debug_activate_cmd_in(act),
        .enter_background_instruction_in(bg), .debug_exit_in(ex), .dbg_addr_in(haddr),
        .dbg_req_in(req), .dbg_write_in(hw), .dbg_grant_out(grant), .dbg_write_ok_out(wok),
        .debug_mode_out(dbm), .vectors_from_debug_out(vec), .mode_out(mode), .e_clock_out(ec),
        .e_stretch_out(e_stretch_enable), .visibility_out(vis), .wide_visible_format_out(wide),
        .narrow_bus_out(nb), .port_e_removed_out(pe), .ext_bus_shutdown_out(shut),
        .sel_debug_rom_out(sv[6]), .sel_debug_regs_out(sv[5]), .sel_regs_out(sv[4]),
        .sel_ram_out(sv[3]), .sel_eeprom_out(sv[2]), .sel_flash_out(sv[1]),
        .sel_external_out(sv[0]));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic rst(input logic [2:0] p);
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        pins <= p;
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
        #1;
    endtask
    task automatic wreg(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_in);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [8:0] a, input logic [7:0] e);
        @(posedge clk_in);
        ra <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 chk("read data", {8'h00, e}, {8'h00, rdata});
    endtask
    // selects, msb first: rom, debug regs, regs, ram, eeprom, flash, external; debug regs is set together with rom for FF00 to FF06 only
    task automatic sel(input logic [15:0] a, input logic [6:0] e);
        @(posedge clk_in);
        ca <= a;
        #1 chk("select", {9'h000, e}, {9'h000, sv});
    endtask
    task automatic cmd(input logic e, input logic a, input logic x);
        @(posedge clk_in);
        en <= e;
        act <= a;
        ex <= x;
        @(posedge clk_in);
        en <= 1'b0;
        act <= 1'b0;
        ex <= 1'b0;
    endtask
    // the host waits through busy cycles; only an idle cycle grants it
    task automatic dbg(input logic [15:0] a, input logic e);
        @(posedge clk_in);
        go <= 1'b1;
        da <= a;
        dw <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        @(posedge clk_in);
        #1 chk("grant busy", 0, grant);
        @(posedge clk_in);
        idle <= 1'b1;
        #1 chk("grant idle", 1, grant);
        chk("write ok", {15'h0000, e}, {15'h0000, wok});
        @(posedge clk_in);
        idle <= 1'b0;
    endtask
    task automatic t_normal_single;
        rst(3'h4);
        chk("mode", 3'h4, mode);
        chk("narrow bus", 0, nb);
        rreg(RAM_POS_OFS, 8'h08);
        sel(16'h0800, 7'h08);
        sel(16'h0C00, 7'h01);
        sel(16'h0000, 7'h10);
        sel(16'h0200, 7'h01);
        sel(16'h0D00, 7'h04);
        sel(16'h8000, 7'h02);
        wreg(RAM_POS_OFS, 8'hF8);
        sel(16'hF800, 7'h08);
        wreg(RAM_POS_OFS, 8'h10);
        rreg(RAM_POS_OFS, 8'hF8);
        rreg(9'h1FE, 8'h00);
        @(posedge clk_in);
        xa <= 1'b1;
        repeat (2) @(posedge clk_in);
        xa <= 1'b0;
        ia <= 1'b1;
        #1 chk("e stretched high", 1, ec);
        repeat (2) @(posedge clk_in);
        ia <= 1'b0;
        #1 chk("e stretched low", 0, ec);
        @(posedge clk_in);
        #1 chk("e free running", 1, ec);
        cmd(1'b0, 1'b1, 1'b0);
        #1 chk("debug without enable", 0, dbm);
        cmd(1'b1, 1'b0, 1'b0);
        cmd(1'b0, 1'b1, 1'b0);
        #1 chk("debug active", 1, dbm);
        sel(16'hFFF0, 7'h40);
        cmd(1'b0, 1'b0, 1'b1);
        sel(16'hFFF0, 7'h02);
        @(posedge clk_in);
        bg <= 1'b1;
        @(posedge clk_in);
        bg <= 1'b0;
        #1 chk("background entry", 1, dbm);
    endtask
    task automatic t_special_single;
        rst(3'h0);
        chk("debug at reset", 1, dbm);
        chk("debug vectors", 1, vec);
        sel(16'hFF03, 7'h60);
        sel(16'hFF07, 7'h40);
        sel(16'hFEFF, 7'h02);
        wreg(REG_POS_OFS, 8'h08);
        sel(16'h0800, 7'h10);
        sel(16'h0A00, 7'h08);
        wreg(REG_POS_OFS, 8'h10);
        sel(16'h0800, 7'h08);
        dbg(16'h0A05, 1'b1);
        dbg(16'h8000, 1'b0);
        wreg(RAM_POS_OFS, 8'h18);
        sel(16'h1800, 7'h08);
        wreg(RAM_POS_OFS, 8'h20);
        wreg(MODE_OFS, 8'h00);
        @(posedge clk_in);
        xa <= 1'b1;
        @(posedge clk_in);
        #1 v[0] = ec;
        @(posedge clk_in);
        xa <= 1'b0;
        #1 chk("e free with stretch off", !v[0], ec);
        wreg(REG_POS_OFS, 8'h11);
        @(posedge clk_in);
        wt <= 1'b1;
        wreg(RAM_POS_OFS, 8'h30);
        rreg(RAM_POS_OFS, 8'h00);
        @(posedge clk_in);
        wt <= 1'b0;
        rreg(RAM_POS_OFS, 8'h20);
    endtask
    task automatic t_special_narrow;
        rst(3'h1);
        rreg(MODE_OFS, 8'h39);
        chk("stretch", 1, e_stretch_enable);
        chk("wide visible", 1, wide);
        chk("port e removed", 1, pe);
        chk("narrow bus", 1, nb);
        sel(16'h0008, 7'h01);
        sel(16'h0007, 7'h10);
        wreg(MODE_OFS, 8'h44);
        #1 chk("mode kept", 3'h1, mode);
        chk("first internal_visibility write", 1, vis);
        rreg(MODE_OFS, 8'h3D);
        @(posedge clk_in);
        wt <= 1'b1;
        repeat (EXT_STOP_CYCLES - 1) @(posedge clk_in);
        #1 chk("shutdown early", 0, shut);
        @(posedge clk_in);
        #1 chk("shutdown", 1, shut);
        @(posedge clk_in);
        wt <= 1'b0;
        #1 chk("shutdown held", 1, shut);
        repeat (2) @(posedge clk_in);
        #1 chk("shutdown left", 0, shut);
        wreg(MODE_OFS, 8'h31);
        #1 chk("internal_visibility cleared", 0, vis);
    endtask
    task automatic t_others;
        rst(3'h5);
        rreg(MODE_OFS, 8'hB0);
        wreg(MODE_OFS, 8'hB8);
        wreg(MODE_OFS, 8'hF0);
        #1 chk("narrow visibility", 0, vis);
        chk("mode write once", 3'h5, mode);
        @(posedge clk_in);
        wt <= 1'b1;
        repeat (12) @(posedge clk_in);
        wt <= 1'b0;
        #1 chk("no shutdown", 0, shut);
        rst(3'h2);
        rreg(MODE_OFS, 8'h00);
        rst(3'h6);
        chk("reserved mode", 3'h2, mode);
    endtask
    initial begin
        t_normal_single();
        t_special_single();
        t_special_narrow();
        t_others();
        results();
    end
    initial begin
        #100000;
        num_errors++;
        results();
    end
endmodule
`default_nettype wire
